// [hdl/flash_mode_pkg.sv]
// constants, field layout and state encodings of the flash led mode control
// assumes a single 250 MHz clock; register offsets are the device's i2c sub-addresses
package flash_mode_pkg;

  // register sub-addresses
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_FLASH_CH1 = 8'h03;
  localparam logic [7:0] REG_FLASH_CH2 = 8'h04;
  localparam logic [7:0] REG_TORCH_CH1 = 8'h05;
  localparam logic [7:0] REG_TORCH_CH2 = 8'h06;
  localparam logic [7:0] REG_FLASH_RAMP = 8'h07;
  localparam logic [7:0] REG_TORCH_RAMP = 8'h08;

  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CURRENT = 8'h00;
  localparam logic [7:0] RST_FLASH_RAMP = 8'h00;
  localparam logic [7:0] RST_TORCH_RAMP = 8'h0A;

  // field positions
  localparam int MODE_LSB = 2;         // mode field is bits 3:2
  localparam int TORCH_PIN_EN_BIT = 4;
  localparam int STROBE_PIN_EN_BIT = 5;
  localparam int STROBE_EDGE_BIT = 6;  // 1 = edge triggered, 0 = level triggered
  localparam int OVERRIDE_BIT = 7;     // in channel-one current registers
  localparam int RAMP_LSB = 4;         // ramp time select is bits 6:4
  localparam int TORCH_EXP_BIT = 7;    // 1 = exponential torch ramp
  localparam int TIMEOUT_LSB = 0;      // timeout select is bits 3:0

  // mode field codes
  localparam logic [1:0] FIELD_STANDBY = 2'b00;
  localparam logic [1:0] FIELD_IR = 2'b01;
  localparam logic [1:0] FIELD_TORCH = 2'b10;
  localparam logic [1:0] FIELD_FLASH = 2'b11;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int FLASH_RAMP_FIRST_US = 512;
  localparam int FLASH_RAMP_UNIT_US = 500;
  localparam int TORCH_RAMP_UNIT_US = 8000;
  localparam int RAMP_STEPS_LOG2 = 7;
  localparam int TIMEOUT_FINE_US = 10000;
  localparam int TIMEOUT_FINE_LAST = 9;
  localparam int TIMEOUT_COARSE_US = 50000;

  // i2c
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2A;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_TORCH = 2'b01,
    MODE_FLASH = 2'b11,
    MODE_IR = 2'b10
  } led_mode_type;

  typedef enum logic [1:0] {
    RAMP_FLASH = 2'b00,
    RAMP_TORCH = 2'b01,
    RAMP_IMMEDIATE = 2'b11
  } ramp_kind_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_REG = 3'b011,
    PH_WRITE = 3'b010,
    PH_READ = 3'b110
  } i2c_phase_type;

endpackage : flash_mode_pkg

// [hdl/edge_sync.sv]
// two-flop synchroniser with edge detection for a group of pin inputs
// assumes inputs are asynchronous to clk; edges come from the synchronised samples
module edge_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  // synchronised level and one-cycle edge pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_state_type;

  sync_state_type st;
  sync_state_type next_st;

  // shift chain; meta feeds only sync
  always_comb begin
    next_st.meta = async_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // edges from the second and third stage only
  assign level = st.sync;
  assign rise = st.sync & ~st.prev;
  assign fall = ~st.sync & st.prev;

endmodule : edge_sync

// [hdl/flash_led_mode_control.sv]
// mode control of a two-channel flash led driver: i2c register slave, mode machine,
// flash timeout and current ramp engine driving the two current source codes
// assumes pins arrive asynchronously and the current sources take the codes each cycle
//
// Behaviour
// [RULE1] enable low: shutdown, registers back to defaults, i2c ignored
// [RULE2] enable high: standby with the i2c slave answering
// [RULE3] host waits the settle time after enable rises before any i2c command
// [RULE4] enable falling cuts both channel currents at once, no ramp
// [RULE5] turning leds off by register write ramps current down to standby
// [RULE6] flash and ir codes 7 and 6 bits, channel one may replace two
// [RULE7] flash ramp time from a 3-bit field, always linear
// [RULE8] flash starts by mode write or enabled strobe rise, ends by write/pin/timeout
// [RULE9] flash timeout clears the mode field back to standby
// [RULE10] level trigger: pin flash ends at strobe fall or timeout
// [RULE11] edge trigger: pin flash ends only at timeout, fall ignored
// [RULE12] torch codes 7 and 6 bits, channel one may replace two
// [RULE13] torch ramp time from a 3-bit field, shape exponential or linear
// [RULE14] torch starts by mode write or enabled torch rise, ends by write or fall
// [RULE15] ir field with strobe enabled: rise enters ir, fall or timeout leaves
// [RULE16] ir current jumps fully on and off with no ramp
// [RULE17] ir always level triggered and still bounded by the flash timeout
// [RULE18] host should set the boost to pass mode for ir use
// [RULE19] field 10 torch, 11 flash, 00 pin modes with flash priority, 01 ir standby
// [RULE20] sixteen timeout settings, counting on through torch fallback
// [RULE21] throttle high in flash drops to torch current, low restores flash
// [RULE22] trigger and throttle pins synchronised, edges from synchronised samples
// [RULE23] a ramp restarts from the present current level, not zero
module flash_led_mode_control
  import flash_mode_pkg::*;
#(
  parameter int CYCLES_PER_US_P = CYCLES_PER_US,
  parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control pins
  input wire logic hardware_enable_pin,
  input wire logic strobe_pin,
  input wire logic torch_pin,
  input wire logic tx_pin,
  // i2c pins, sda open drain
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // current source codes and active mode
  output logic [6:0] channel_one_output,
  output logic [5:0] channel_two_output,
  output logic [1:0] led_mode
);

  typedef struct packed {
    logic [7:0] mode_reg;
    logic [7:0] flash_ch1;
    logic [7:0] flash_ch2;
    logic [7:0] torch_ch1;
    logic [7:0] torch_ch2;
    logic [7:0] flash_ramp;
    logic [7:0] torch_ramp;
    led_mode_type mode;
    logic pin_started;
    ramp_kind_type ramp_kind;
    logic [6:0] ch1;
    logic [5:0] ch2;
    logic [11:0] pre;
    logic [13:0] step_cnt;
    logic [18:0] to_cnt;
    i2c_phase_type phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic sda_out;
  } state_type;

  localparam state_type STATE_RESET = '{
    mode_reg: RST_MODE, flash_ch1: RST_CURRENT, flash_ch2: RST_CURRENT,
    torch_ch1: RST_CURRENT, torch_ch2: RST_CURRENT, flash_ramp: RST_FLASH_RAMP,
    torch_ramp: RST_TORCH_RAMP, mode: MODE_STANDBY, pin_started: 1'b0,
    ramp_kind: RAMP_FLASH, ch1: 7'h00, ch2: 6'h00, pre: 12'h000, step_cnt: 14'h0000,
    to_cnt: 19'h00000, phase: PH_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
    rw: 1'b0, sda_oe: 1'b0, sda_out: 1'b0};

  // channel-one code limited to the channel-two range
  function automatic logic [5:0] sat6(input logic [6:0] code);
    sat6 = code[6] ? 6'h3F : code[5:0];
  endfunction : sat6

  // move a level toward its target by at most size codes
  function automatic logic [6:0] step_toward(input logic [6:0] lvl, input logic [6:0] target,
                                             input logic [6:0] size);
    if (lvl < target) begin
      step_toward = ((target - lvl) > size) ? lvl + size : target;
    end else if (lvl > target) begin
      step_toward = ((lvl - target) > size) ? lvl - size : target;
    end else begin
      step_toward = lvl;
    end
  endfunction : step_toward

  // microseconds between ramp steps for the selected ramp kind
  function automatic logic [13:0] step_interval(input ramp_kind_type kind,
                                                input logic [2:0] flash_sel,
                                                input logic [2:0] torch_sel);
    int ramp_us;
    ramp_us = 0;
    if (kind == RAMP_FLASH) begin
      ramp_us = (flash_sel == 3'h0) ? FLASH_RAMP_FIRST_US
                                    : FLASH_RAMP_UNIT_US << flash_sel;
    end else if (kind == RAMP_TORCH && torch_sel != 3'h0) begin
      ramp_us = TORCH_RAMP_UNIT_US << torch_sel;
    end
    step_interval = 14'(ramp_us >> RAMP_STEPS_LOG2);
  endfunction : step_interval

  // flash timeout in microseconds: 10 ms steps up to 100 ms, then 50 ms steps
  function automatic logic [18:0] timeout_us(input logic [3:0] sel);
    int t;
    if (int'(sel) <= TIMEOUT_FINE_LAST) begin
      t = (int'(sel) + 1) * TIMEOUT_FINE_US;
    end else begin
      t = (TIMEOUT_FINE_LAST + 1) * TIMEOUT_FINE_US
          + (int'(sel) - TIMEOUT_FINE_LAST) * TIMEOUT_COARSE_US;
    end
    timeout_us = 19'(t);
  endfunction : timeout_us

  state_type st;
  state_type next_st;

  logic [5:0] pin_level;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic hardware_enable_pin_lvl;
  logic strobe_lvl;
  logic strobe_rise;
  logic strobe_fall;
  logic torch_rise;
  logic torch_fall;
  logic tx_lvl;
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  logic us_tick;
  logic wr_en;
  logic wr_mode;
  logic timeout_hit;
  logic [7:0] rd_data;
  logic [1:0] field;
  logic [6:0] tgt1;
  logic [5:0] tgt2;
  logic [13:0] interval;
  logic [6:0] size1;
  logic [6:0] size2;

  // all pins pass two flops before use; edges come from synchronised samples
  edge_sync #(.WIDTH(6)) pin_sync ( // [RULE22]
    .clk(clk),
    .rst(rst),
    .async_in({hardware_enable_pin, strobe_pin, torch_pin, tx_pin, scl, sda_in}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // unpack the synchronised pins
  assign {hardware_enable_pin_lvl, strobe_lvl, scl_lvl, sda_lvl} =
    {pin_level[5], pin_level[4], pin_level[1], pin_level[0]};
  assign tx_lvl = pin_level[2];
  assign {strobe_rise, strobe_fall} = {pin_rise[4], pin_fall[4]};
  assign {torch_rise, torch_fall} = {pin_rise[3], pin_fall[3]};
  assign {scl_rise, scl_fall} = {pin_rise[1], pin_fall[1]};
  assign {sda_rise, sda_fall} = {pin_rise[0], pin_fall[0]};

  // i2c slave, register file, mode machine, timeout and ramp engine
  always_comb begin
    next_st = st;
    wr_en = 1'b0;
    rd_data = 8'h00;
    // microsecond prescaler
    us_tick = (st.pre == 12'(CYCLES_PER_US_P - 1));
    next_st.pre = us_tick ? 12'h000 : st.pre + 12'h001;
    // read decode at the pointer
    case (st.ptr)
      REG_MODE: rd_data = st.mode_reg;
      REG_FLASH_CH1: rd_data = st.flash_ch1;
      REG_FLASH_CH2: rd_data = st.flash_ch2;
      REG_TORCH_CH1: rd_data = st.torch_ch1;
      REG_TORCH_CH2: rd_data = st.torch_ch2;
      REG_FLASH_RAMP: rd_data = st.flash_ramp;
      REG_TORCH_RAMP: rd_data = st.torch_ramp;
      default: rd_data = 8'h00;
    endcase
    // i2c bit engine: start and stop seen while scl is high
    if (scl_lvl && sda_fall) begin
      next_st.phase = PH_ADDR;
      next_st.bitcnt = 4'hF; // the first scl fall only closes the start
      next_st.sda_oe = 1'b0;
    end else if (scl_lvl && sda_rise) begin
      next_st.phase = PH_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (st.phase != PH_IDLE && scl_rise) begin
      if (st.phase != PH_READ && st.bitcnt < ACK_SLOT) begin
        next_st.shreg = {st.shreg[6:0], sda_lvl};
      end else if (st.phase == PH_READ && st.bitcnt == ACK_SLOT && sda_lvl) begin
        next_st.phase = PH_IDLE; // master nack ends the read
      end
    end else if (st.phase != PH_IDLE && scl_fall) begin
      if (st.bitcnt == 4'hF) begin
        next_st.bitcnt = 4'h0; // fall after a start opens the first bit
      end else if (st.bitcnt < LAST_DATA_BIT) begin
        next_st.bitcnt = st.bitcnt + 4'h1;
        if (st.phase == PH_READ) begin
          next_st.shreg = {st.shreg[6:0], 1'b0};
          next_st.sda_oe = ~st.shreg[6];
        end
      end else if (st.bitcnt == LAST_DATA_BIT) begin
        next_st.bitcnt = ACK_SLOT;
        unique case (st.phase)
          PH_ADDR: begin
            if (st.shreg[7:1] == SLAVE_ADDR) begin
              next_st.sda_oe = 1'b1;
              next_st.rw = st.shreg[0];
            end else begin
              next_st.phase = PH_IDLE;
            end
          end
          PH_REG: begin
            next_st.ptr = st.shreg;
            next_st.sda_oe = 1'b1;
          end
          PH_WRITE: begin
            wr_en = 1'b1;
            next_st.ptr = st.ptr + 8'h01;
            next_st.sda_oe = 1'b1;
          end
          PH_READ: next_st.sda_oe = 1'b0;
          default: next_st.phase = PH_IDLE;
        endcase
      end else begin
        // end of the acknowledge slot
        next_st.bitcnt = 4'h0;
        next_st.sda_oe = 1'b0;
        if (st.phase == PH_ADDR) begin
          next_st.phase = st.rw ? PH_READ : PH_REG;
        end else if (st.phase == PH_REG) begin
          next_st.phase = PH_WRITE;
        end
        if (next_st.phase == PH_READ) begin
          next_st.shreg = rd_data;
          next_st.ptr = st.ptr + 8'h01;
          next_st.sda_oe = ~rd_data[7];
        end
      end
    end
    // register writes; unmapped addresses are dropped
    if (wr_en) begin
      case (st.ptr)
        REG_MODE: next_st.mode_reg = st.shreg;
        REG_FLASH_CH1: next_st.flash_ch1 = st.shreg;
        REG_FLASH_CH2: next_st.flash_ch2 = st.shreg;
        REG_TORCH_CH1: next_st.torch_ch1 = st.shreg;
        REG_TORCH_CH2: next_st.torch_ch2 = st.shreg;
        REG_FLASH_RAMP: next_st.flash_ramp = st.shreg;
        REG_TORCH_RAMP: next_st.torch_ramp = st.shreg;
        default: ;
      endcase
    end
    wr_mode = wr_en && (st.ptr == REG_MODE);
    field = next_st.mode_reg[MODE_LSB +: 2];
    // timeout keeps counting through the throttle fallback
    timeout_hit = (st.mode == MODE_FLASH || st.mode == MODE_IR)
                  && (st.to_cnt >= timeout_us(next_st.torch_ramp[TIMEOUT_LSB +: 4])); // [RULE20]
    // mode machine
    if (wr_mode) begin
      next_st.pin_started = 1'b0;
      if (field == FIELD_TORCH) begin
        next_st.mode = MODE_TORCH; // [RULE14] [RULE19]
      end else if (field == FIELD_FLASH) begin
        next_st.mode = MODE_FLASH; // [RULE8] [RULE19]
      end else begin
        next_st.mode = MODE_STANDBY; // [RULE5] [RULE8]
      end
    end else begin
      unique case (st.mode)
        MODE_STANDBY: begin
          if (field == FIELD_STANDBY && st.mode_reg[STROBE_PIN_EN_BIT] && strobe_rise) begin
            next_st.mode = MODE_FLASH; // [RULE8] [RULE19]
            next_st.pin_started = 1'b1;
          end else if (field == FIELD_STANDBY && st.mode_reg[TORCH_PIN_EN_BIT] && torch_rise) begin
            next_st.mode = MODE_TORCH; // [RULE14]
            next_st.pin_started = 1'b1;
          end else if (field == FIELD_IR && st.mode_reg[STROBE_PIN_EN_BIT] && strobe_rise) begin
            next_st.mode = MODE_IR; // [RULE15]
          end
        end
        MODE_TORCH: begin
          if (st.pin_started && st.mode_reg[STROBE_PIN_EN_BIT] && strobe_rise) begin
            next_st.mode = MODE_FLASH; // [RULE19]
          end else if (st.pin_started && torch_fall) begin
            next_st.mode = MODE_STANDBY; // [RULE14]
            next_st.pin_started = 1'b0;
          end
        end
        MODE_FLASH: begin
          if (timeout_hit) begin
            next_st.mode = MODE_STANDBY; // [RULE8]
            next_st.pin_started = 1'b0;
            if (!st.pin_started) begin
              next_st.mode_reg[MODE_LSB +: 2] = FIELD_STANDBY; // [RULE9]
            end
          end else if (st.pin_started && !st.mode_reg[STROBE_EDGE_BIT] && strobe_fall) begin
            next_st.mode = MODE_STANDBY; // [RULE10] [RULE11]
            next_st.pin_started = 1'b0;
          end
        end
        MODE_IR: begin
          if (timeout_hit || strobe_fall) begin
            next_st.mode = MODE_STANDBY; // [RULE15] [RULE17]
          end
        end
      endcase
    end
    // timeout counter runs in microseconds while flash or ir lasts
    if ((next_st.mode == MODE_FLASH || next_st.mode == MODE_IR)
        && (st.mode == MODE_FLASH || st.mode == MODE_IR)) begin
      next_st.to_cnt = (us_tick && !timeout_hit) ? st.to_cnt + 19'h00001 : st.to_cnt;
    end else begin
      next_st.to_cnt = 19'h00000;
    end
    // targets; channel one may replace channel two
    tgt1 = 7'h00;
    tgt2 = 6'h00;
    if (next_st.mode == MODE_TORCH || (next_st.mode == MODE_FLASH && tx_lvl)) begin
      tgt1 = next_st.torch_ch1[6:0]; // [RULE12] [RULE21]
      tgt2 = next_st.torch_ch1[OVERRIDE_BIT] ? sat6(next_st.torch_ch1[6:0])
                                             : next_st.torch_ch2[5:0];
    end else if (next_st.mode != MODE_STANDBY) begin
      tgt1 = next_st.flash_ch1[6:0]; // [RULE6]
      tgt2 = next_st.flash_ch1[OVERRIDE_BIT] ? sat6(next_st.flash_ch1[6:0])
                                             : next_st.flash_ch2[5:0];
    end
    // ramp kind follows the active mode; standby keeps the kind it ramps down with
    if (next_st.mode == MODE_IR || (st.mode == MODE_IR && next_st.mode == MODE_STANDBY)) begin
      next_st.ramp_kind = RAMP_IMMEDIATE; // [RULE16]
    end else if (next_st.mode == MODE_TORCH) begin
      next_st.ramp_kind = RAMP_TORCH;
    end else if (next_st.mode == MODE_FLASH) begin
      next_st.ramp_kind = RAMP_FLASH; // [RULE7]
    end
    interval = step_interval(next_st.ramp_kind, next_st.flash_ramp[RAMP_LSB +: 3],
                             next_st.torch_ramp[RAMP_LSB +: 3]); // [RULE7] [RULE13]
    // exponential torch ramp steps in proportion to the level
    size1 = 7'h01;
    size2 = 7'h01;
    if (next_st.ramp_kind == RAMP_TORCH && next_st.torch_ramp[TORCH_EXP_BIT]) begin
      size1 = {4'h0, st.ch1[6:4]} + 7'h01; // [RULE13]
      size2 = {5'h00, st.ch2[5:4]} + 7'h01;
    end
    // ramp engine steps from the present level
    if (next_st.ramp_kind == RAMP_IMMEDIATE || interval == 14'h0000) begin
      next_st.ch1 = tgt1; // [RULE16]
      next_st.ch2 = tgt2;
      next_st.step_cnt = 14'h0000;
    end else if (us_tick) begin
      if (st.step_cnt + 14'h0001 >= interval) begin
        next_st.step_cnt = 14'h0000;
        next_st.ch1 = step_toward(st.ch1, tgt1, size1); // [RULE23] [RULE5]
        next_st.ch2 = 6'(step_toward({1'b0, st.ch2}, {1'b0, tgt2}, size2));
      end else begin
        next_st.step_cnt = st.step_cnt + 14'h0001;
      end
    end
    next_st.sda_out = 1'b0;
    // enable low holds everything in shutdown; enable high leaves standby with i2c live
    if (!hardware_enable_pin_lvl) begin
      next_st = STATE_RESET; // [RULE1] [RULE2] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign channel_one_output = st.ch1;
  assign channel_two_output = st.ch2;
  assign led_mode = st.mode;
  assign sda_oe = st.sda_oe;
  assign sda_out = st.sda_out;

  // checks
  chk_shutdown_clear: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    !hardware_enable_pin_lvl |=> st.mode_reg == RST_MODE && st.ch1 == 7'h00 && !st.sda_oe)
    else $error("shutdown did not clear state");
  chk_hardware_enable_pin_cut: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    $fell(hardware_enable_pin_lvl) |=> channel_one_output == 7'h00 && channel_two_output == 6'h00)
    else $error("current not cut at enable fall");
  chk_ramp_down: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    hardware_enable_pin_lvl && st.mode == MODE_STANDBY && st.ramp_kind != RAMP_IMMEDIATE
    && st.ch1 > 7'h10 ##1 hardware_enable_pin_lvl |-> st.ch1 != 7'h00)
    else $error("current dropped without ramp");
  chk_timeout_field: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    hardware_enable_pin_lvl && timeout_hit && st.mode == MODE_FLASH && !st.pin_started && !wr_mode
    |=> st.mode_reg[MODE_LSB +: 2] == FIELD_STANDBY && st.mode == MODE_STANDBY)
    else $error("timeout did not clear mode field");
  chk_level_end: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    hardware_enable_pin_lvl && st.mode == MODE_FLASH && st.pin_started && !st.mode_reg[STROBE_EDGE_BIT]
    && strobe_fall && !wr_mode |=> st.mode == MODE_STANDBY)
    else $error("level flash kept past strobe fall");
  chk_edge_hold: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    hardware_enable_pin_lvl && st.mode == MODE_FLASH && st.pin_started && st.mode_reg[STROBE_EDGE_BIT]
    && strobe_fall && !timeout_hit && !wr_mode |=> st.mode == MODE_FLASH)
    else $error("edge flash ended at strobe fall");
  chk_ir_level: assert property (@(posedge clk) disable iff (rst) // [RULE16]
    st.mode == MODE_IR |-> st.ch1 == st.flash_ch1[6:0])
    else $error("ir current not at full setting");
  chk_ir_off: assert property (@(posedge clk) disable iff (rst) // [RULE17]
    st.mode == MODE_IR && strobe_fall && !wr_mode |=> st.ch1 == 7'h00 && st.ch2 == 6'h00)
    else $error("ir current not off at strobe fall");
  chk_flash_wins: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    hardware_enable_pin_lvl && st.mode == MODE_STANDBY && st.mode_reg[MODE_LSB +: 2] == FIELD_STANDBY
    && st.mode_reg[STROBE_PIN_EN_BIT] && st.mode_reg[TORCH_PIN_EN_BIT]
    && strobe_rise && !wr_en |=> st.mode == MODE_FLASH)
    else $error("flash trigger lost priority");
  chk_field_torch: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    st.mode_reg[MODE_LSB +: 2] == FIELD_TORCH |-> st.mode == MODE_TORCH)
    else $error("torch field without torch mode");

endmodule : flash_led_mode_control

// [testbench/host_i2c.sv]
// host model: i2c master, drives scl and pulls sda low or lets it go
// assumes the bench builds the sda wire with its pull-up
module host_i2c
  import flash_mode_pkg::*;
(
  // clock and i2c lines
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial {scl, sda_low} = 2'b10;
  // two line states, each held a quarter of the scl period
  task automatic seq(input logic [3:0] v);
    {scl, sda_low} = v[3:2];
    repeat (5) @(negedge clk);
    {scl, sda_low} = v[1:0];
    repeat (5) @(negedge clk);
  endtask : seq
  // nine bits msb first, the last one the ack slot; sda only moves with scl low
  task automatic byte_io(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      seq({1'b0, ~d[i], 1'b1, ~d[i]});
      r[i] = sda;
      seq({1'b1, ~d[i], 1'b0, ~d[i]});
    end
  endtask : byte_io
  // one register write or read, framed by start and stop
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic [8:0] b;
    seq(4'b0010);
    seq(4'b1101);
    byte_io({DEFAULT_SLAVE_ADDR, 2'b01}, b);
    byte_io({a, 1'b1}, b);
    if (rd) begin
      seq(4'b0010);
      seq(4'b1101);
      byte_io({DEFAULT_SLAVE_ADDR, 2'b11}, b);
    end
    byte_io(rd ? 9'h1FF : {d, 1'b1}, b);
    r = rd ? b[8:1] : {7'h00, b[0]};  // a write returns its last ack bit
    seq(4'b0111);
    seq(4'b1010);
  endtask : xfer
endmodule : host_i2c

// [testbench/flash_led_mode_control_tb.sv]
// bench: host model on i2c, pins and checks driven here
// assumes timers cut to 2 clocks per microsecond
module flash_led_mode_control_tb
  import flash_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // bench signals, sda is open drain with a pull-up
  logic clk, rst, en, strobe, torch, tx, scl, sda_low, sda_out, sda_oe;
  logic [6:0] ch1;
  logic [5:0] ch2;
  logic [1:0] mode;
  int num_errors = 0;
  int n_tests = 0;
  wire logic sda = ~(sda_low | sda_oe);
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  flash_led_mode_control #(.CYCLES_PER_US_P(2)) uut (.clk(clk), .rst(rst),
    .hardware_enable_pin(en), .strobe_pin(strobe), .torch_pin(torch), .tx_pin(tx),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .channel_one_output(ch1), .channel_two_output(ch2), .led_mode(mode));
  host_i2c host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  // compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register write with its ack checked, or read compared with d
  task automatic io(input logic rd, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(rd, a, d, r);
    if (rd) chk("reg", {8'h00, d}, {8'h00, r});
    else chk("ack", 16'h0000, {8'h00, r});
  endtask : io
  // wait n cycles, then compare both codes and the mode
  task automatic at(input int n, input logic [6:0] a, input logic [5:0] b, input logic [1:0] m);
    repeat (n) @(negedge clk);
    chk("out", {1'b0, a, b, m}, {sda_out, ch1, ch2, mode});
  endtask : at
  // verdict
  task automatic close_out;
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // watchdog
  initial begin
    repeat (60000) @(negedge clk);
    num_errors++;
    close_out();
  end
  // tests
  initial begin
    {rst, en, strobe, torch, tx} = 5'h18;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (400) @(negedge clk);
    io(1'b1, REG_MODE, RST_MODE);
    io(1'b0, REG_TORCH_RAMP, 8'h00);
    io(1'b0, REG_FLASH_CH1, 8'h90);
    io(1'b0, REG_TORCH_CH1, 8'h87);
    io(1'b0, REG_MODE, 8'h0C);
    at(300, 7'h10, 6'h10, MODE_FLASH);
    tx = 1'b1;
    at(300, 7'h07, 6'h07, MODE_FLASH);
    tx = 1'b0;
    io(1'b0, REG_MODE, 8'h00);
    chk("ramp", 16'h0001, {15'h0000, ch1 != 7'h00});
    at(300, 7'h00, 6'h00, MODE_STANDBY);
    io(1'b0, REG_MODE, 8'h24);
    strobe = 1'b1;
    at(10, 7'h10, 6'h10, MODE_IR);
    strobe = 1'b0;
    at(10, 7'h00, 6'h00, MODE_STANDBY);
    io(1'b0, REG_MODE, 8'h30);
    torch = 1'b1;
    at(10, 7'h07, 6'h07, MODE_TORCH);
    strobe = 1'b1;
    at(300, 7'h10, 6'h10, MODE_FLASH);
    {strobe, torch} = 2'b00;
    at(300, 7'h00, 6'h00, MODE_STANDBY);
    io(1'b0, REG_MODE, 8'h08);
    at(10, 7'h07, 6'h07, MODE_TORCH);
    io(1'b0, REG_MODE, 8'h0C);
    at(20400, 7'h00, 6'h00, MODE_STANDBY);
    io(1'b1, REG_MODE, 8'h00);
    io(1'b0, REG_MODE, 8'h60);
    strobe = 1'b1;
    at(300, 7'h10, 6'h10, MODE_FLASH);
    strobe = 1'b0;
    at(300, 7'h10, 6'h10, MODE_FLASH);
    en = 1'b0;
    at(5, 7'h00, 6'h00, MODE_STANDBY);
    io(1'b1, REG_MODE, 8'hFF);
    en = 1'b1;
    repeat (400) @(negedge clk);
    io(1'b1, REG_MODE, RST_MODE);
    close_out();
  end
endmodule : flash_led_mode_control_tb
